/* hw/ppc_addr_match.sv */
// Purpose : Decide whether a destination address is an enabled PTP address
// Assumes : Enables and auxiliary address come from registers on the same clock
// Notes   : Purely combinational; the caller registers any decision it keeps
module ppc_addr_match
   import ppc_pkg::*;
(
   input  wire logic [47:0] dst_addr,     // Frame destination address
   input  wire logic [3:0]  fixed_en,     // Enables: primary, alt a, alt b, alt c
   input  wire logic        aux_en,       // Auxiliary address enable
   input  wire logic [47:0] aux_addr,     // Software programmed address
   output logic             is_ptp_addr   // Address counts as PTP
);

   // ------------------------------------------------------------------
   // Per-address compare
   // ------------------------------------------------------------------
   localparam logic [47:0] FIXED_ADDR [4] = '{PPC_ADDR_PRI, PPC_ADDR_ALT_A,
                                              PPC_ADDR_ALT_B, PPC_ADDR_ALT_C};
   logic [3:0] hit_vec;  // One hit per fixed address

   // Each fixed address counts only while its own enable is set
   for (genvar i = 0; i < 4; i++) begin : g_fixed
      assign hit_vec[i] = fixed_en[i] && (dst_addr == FIXED_ADDR[i]);
   end

   // Auxiliary compare and combine
   always_comb begin
      is_ptp_addr = (|hit_vec) || (aux_en && (dst_addr == aux_addr));
   end

endmodule : ppc_addr_match

/* hw/ppc_capture_cfg.sv */
// Purpose : PTP capture configuration, port 0 classifier and capture slots
// Assumes : Packet path strobes and time are on clk_sys; APB slave for software
// Notes   : Port 1 events arrive already classified by the port 1 path
//
// The APB register port and the placing of the registers were left to the implementer.
module ppc_capture_cfg
   import ppc_pkg::*;
(
   input  wire logic        clk_sys,          // System clock, 10 MHz
   input  wire logic        rst,              // Asynchronous reset, active high
   // APB slave
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [11:0] paddr,
   input  wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic        pready,
   output logic        pslverr,
   // Time base
   input  wire logic [63:0] ts_clock,
   // Port 0, frames leaving the fabric toward the host MAC
   input  wire logic        p0_from_fab_valid,
   input  wire logic [3:0]  p0_from_fab_msg,
   input  wire logic [47:0] p0_from_fab_dst,
   input  wire logic [15:0] p0_from_fab_seq,
   input  wire logic [15:0] p0_from_fab_src,
   // Port 0, frames entering the fabric from the host MAC
   input  wire logic        p0_to_fab_valid,
   input  wire logic [3:0]  p0_to_fab_msg,
   input  wire logic [47:0] p0_to_fab_dst,
   input  wire logic [15:0] p0_to_fab_seq,
   input  wire logic [15:0] p0_to_fab_src,
   // Port 1, already qualified capture events
   input  wire logic        p1_rx_event,
   input  wire logic [15:0] p1_rx_seq,
   input  wire logic [15:0] p1_rx_src,
   input  wire logic        p1_tx_event,
   input  wire logic [15:0] p1_tx_seq,
   input  wire logic [15:0] p1_tx_src,
   // Interrupt
   output logic        irq
);

   // ------------------------------------------------------------------
   // Software registers
   // ------------------------------------------------------------------
   logic [31:0] cfg_reg;       // Capture port configuration
   logic [31:0] cfg_next;
   logic [15:0] aux_hi_reg;    // aux_ptp_addr_high
   logic [15:0] aux_hi_next;
   logic [31:0] aux_lo_reg;    // aux_ptp_addr_low
   logic [31:0] aux_lo_next;
   logic [3:0]  sts_reg;       // Sticky capture flags
   logic [3:0]  sts_next;
   logic [3:0]  mask_reg;      // Interrupt mask
   logic [3:0]  mask_next;
   logic        irq_reg;       // Registered interrupt level
   logic        irq_next;

   // ------------------------------------------------------------------
   // Bus handshake state
   // ------------------------------------------------------------------
   ppc_bus_type bus_reg;       // Idle or answering
   ppc_bus_type bus_next;
   logic [31:0] rdata_reg;     // Read data held for the answer
   logic [31:0] rdata_next;
   logic        err_reg;       // Unmapped address answer
   logic        err_next;

   // ------------------------------------------------------------------
   // Configuration field views
   // ------------------------------------------------------------------
   logic        role_master_p0;   // time_master_role_p0
   logic [3:0]  fixed_en_p0;      // Primary and alternates for port 0
   logic        aux_en_p0;        // aux_ptp_addr_en_p0
   logic [3:0]  lock_vec;         // Lock per slot
   logic [47:0] aux_addr;         // Full auxiliary address

   assign role_master_p0 = cfg_reg[PPC_BIT_ROLE_P0];
   assign fixed_en_p0    = {cfg_reg[PPC_BIT_ALT_C_P0], cfg_reg[PPC_BIT_ALT_B_P0],
                            cfg_reg[PPC_BIT_ALT_A_P0], cfg_reg[PPC_BIT_PRI_P0]};
   assign aux_en_p0      = cfg_reg[PPC_BIT_AUX_P0];
   assign lock_vec       = {cfg_reg[PPC_BIT_LOCK_TX_P1], cfg_reg[PPC_BIT_LOCK_RX_P1],
                            cfg_reg[PPC_BIT_LOCK_TX_P0], cfg_reg[PPC_BIT_LOCK_RX_P0]};
   assign aux_addr       = {aux_hi_reg, aux_lo_reg};

   // ------------------------------------------------------------------
   // Port 0 address match, one per direction
   // ------------------------------------------------------------------
   logic from_fab_ptp;   // Destination is PTP, fabric to host
   logic to_fab_ptp;     // Destination is PTP, host to fabric

   ppc_addr_match u_match_from_fab (
      .dst_addr    (p0_from_fab_dst),
      .fixed_en    (fixed_en_p0),
      .aux_en      (aux_en_p0),
      .aux_addr    (aux_addr),
      .is_ptp_addr (from_fab_ptp)
   );

   ppc_addr_match u_match_to_fab (
      .dst_addr    (p0_to_fab_dst),
      .fixed_en    (fixed_en_p0),
      .aux_en      (aux_en_p0),
      .aux_addr    (aux_addr),
      .is_ptp_addr (to_fab_ptp)
   );

   // ------------------------------------------------------------------
   // Port 0 role classifier
   // ------------------------------------------------------------------
   logic        cap_p0_rx;            // Qualified port 0 receive capture
   logic        cap_p0_tx;            // Qualified port 0 transmit capture
   ppc_msg_type rx_want;              // Message type captured on receive
   ppc_msg_type tx_want;              // Message type captured on transmit

   // Receive is the path out of the fabric, transmit the path into it
   always_comb begin
      if (role_master_p0) begin
         rx_want = PPC_MSG_DELAY_REQ;
         tx_want = PPC_MSG_SYNC;
      end else begin
         rx_want = PPC_MSG_SYNC;
         tx_want = PPC_MSG_DELAY_REQ;
      end
      cap_p0_rx = p0_from_fab_valid && from_fab_ptp && (p0_from_fab_msg == rx_want);
      cap_p0_tx = p0_to_fab_valid && to_fab_ptp && (p0_to_fab_msg == tx_want);
   end

   // ------------------------------------------------------------------
   // Capture slots
   // ------------------------------------------------------------------
   logic [3:0]  cap_vec;               // Capture request per slot
   logic [15:0] seq_arr [PPC_NUM_SLOTS];
   logic [15:0] src_arr [PPC_NUM_SLOTS];
   logic [63:0] slot_clk [PPC_NUM_SLOTS];
   logic [31:0] slot_ids [PPC_NUM_SLOTS];

   assign cap_vec = {p1_tx_event, p1_rx_event, cap_p0_tx, cap_p0_rx};
   assign seq_arr[PPC_SLOT_P0_RX] = p0_from_fab_seq;
   assign seq_arr[PPC_SLOT_P0_TX] = p0_to_fab_seq;
   assign seq_arr[PPC_SLOT_P1_RX] = p1_rx_seq;
   assign seq_arr[PPC_SLOT_P1_TX] = p1_tx_seq;
   assign src_arr[PPC_SLOT_P0_RX] = p0_from_fab_src;
   assign src_arr[PPC_SLOT_P0_TX] = p0_to_fab_src;
   assign src_arr[PPC_SLOT_P1_RX] = p1_rx_src;
   assign src_arr[PPC_SLOT_P1_TX] = p1_tx_src;

   // One slot per port and direction, each gated by its own lock and flag
   for (genvar s = 0; s < PPC_NUM_SLOTS; s++) begin : g_slot
      ppc_capture_slot u_slot (
         .clk_sys  (clk_sys),
         .rst      (rst),
         .cap_req  (cap_vec[s]),
         .lock_en  (lock_vec[s]),
         .flag_set (sts_reg[s]),
         .ts_clock (ts_clock),
         .seq_id   (seq_arr[s]),
         .src_id   (src_arr[s]),
         .clk_q    (slot_clk[s]),
         .ids_q    (slot_ids[s])
      );
   end

   // ------------------------------------------------------------------
   // Address decode and read mux
   // ------------------------------------------------------------------
   logic [31:0] rd_val;     // Word at the addressed location
   logic        rd_hit;     // Address is mapped
   logic [11:0] slot_ofs;   // Offset into the slot area
   logic [1:0]  slot_sel;   // Addressed slot

   always_comb begin
      rd_val   = 32'h00000000;
      rd_hit   = 1'b1;
      slot_ofs = paddr - PPC_OFS_SLOT0;
      slot_sel = slot_ofs[5:4];
      case (paddr)
         PPC_OFS_CFG:      rd_val = cfg_reg;
         PPC_OFS_AUX_HI:   rd_val = {16'h0000, aux_hi_reg};
         PPC_OFS_AUX_LO:   rd_val = aux_lo_reg;
         PPC_OFS_INT_STS:  rd_val = {28'h0000000, sts_reg};
         PPC_OFS_INT_MASK: rd_val = {28'h0000000, mask_reg};
         default: begin
            // Slot area: four slots of three words each
            if (paddr >= PPC_OFS_SLOT0 && slot_ofs < (PPC_SLOT_STRIDE * 12'h004)
                && paddr[1:0] == 2'b00) begin
               case (slot_ofs[3:0])
                  PPC_SUB_CLK_LO: rd_val = slot_clk[slot_sel][31:0];
                  PPC_SUB_CLK_HI: rd_val = slot_clk[slot_sel][63:32];
                  PPC_SUB_IDS:    rd_val = slot_ids[slot_sel];
                  default:        rd_hit = 1'b0;
               endcase
            end else begin
               rd_hit = 1'b0;
            end
         end
      endcase
   end

   // ------------------------------------------------------------------
   // APB handshake: answer one cycle into the access phase
   // ------------------------------------------------------------------
   logic wr_fire;   // Write takes effect this edge

   always_comb begin
      bus_next   = bus_reg;
      rdata_next = rdata_reg;
      err_next   = err_reg;
      wr_fire    = 1'b0;
      case (bus_reg)
         PPC_BUS_IDLE: begin
            // Access phase seen: latch answer and raise pready
            if (psel && penable) begin
               bus_next   = PPC_BUS_DONE;
               rdata_next = pwrite ? 32'h00000000 : rd_val;
               err_next   = !rd_hit;
            end
         end
         PPC_BUS_DONE: begin
            // Master samples pready now; write commits at this edge
            wr_fire    = psel && penable && pwrite && !err_reg;
            bus_next   = PPC_BUS_IDLE;
            rdata_next = 32'h00000000;
            err_next   = 1'b0;
         end
         default: bus_next = PPC_BUS_IDLE;
      endcase
   end

   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         bus_reg   <= PPC_BUS_IDLE;
         rdata_reg <= 32'h00000000;
         err_reg   <= 1'b0;
      end else begin
         bus_reg   <= bus_next;
         rdata_reg <= rdata_next;
         err_reg   <= err_next;
      end
   end

   // ------------------------------------------------------------------
   // Register writes, sticky flags and interrupt
   // ------------------------------------------------------------------
   always_comb begin
      cfg_next    = cfg_reg;
      aux_hi_next = aux_hi_reg;
      aux_lo_next = aux_lo_reg;
      mask_next   = mask_reg;
      sts_next    = sts_reg;
      // Software writes; reserved configuration bits stay zero
      if (wr_fire) begin
         case (paddr)
            PPC_OFS_CFG:      cfg_next    = pwdata & PPC_CFG_WMASK;
            PPC_OFS_AUX_HI:   aux_hi_next = pwdata[15:0];
            PPC_OFS_AUX_LO:   aux_lo_next = pwdata[31:0];
            PPC_OFS_INT_MASK: mask_next   = pwdata[3:0];
            PPC_OFS_INT_STS:  sts_next    = sts_reg & ~pwdata[3:0];
            default:          cfg_next    = cfg_reg;
         endcase
      end
      // A capture event in the clear cycle still sets its flag
      sts_next = sts_next | cap_vec;
      irq_next = |(sts_next & mask_next);
   end

   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         cfg_reg    <= PPC_CFG_RESET;
         aux_hi_reg <= PPC_AUX_HI_RST;
         aux_lo_reg <= PPC_AUX_LO_RST;
         sts_reg    <= PPC_STS_RESET;
         mask_reg   <= PPC_MASK_RESET;
         irq_reg    <= 1'b0;
      end else begin
         cfg_reg    <= cfg_next;
         aux_hi_reg <= aux_hi_next;
         aux_lo_reg <= aux_lo_next;
         sts_reg    <= sts_next;
         mask_reg   <= mask_next;
         irq_reg    <= irq_next;
      end
   end

   // ------------------------------------------------------------------
   // Outputs, all from flip-flops
   // ------------------------------------------------------------------
   assign prdata  = rdata_reg;
   assign pready  = (bus_reg == PPC_BUS_DONE);
   assign pslverr = err_reg;
   assign irq     = irq_reg;

endmodule : ppc_capture_cfg

/* hw/ppc_capture_slot.sv */
// Purpose : Hold one captured timestamp with source and sequence identity
// Assumes : Capture request is a one-cycle pulse on the system clock
// Notes   : A locked slot with its flag pending keeps the earlier values
module ppc_capture_slot
   import ppc_pkg::*;
(
   input  wire logic        clk_sys,    // System clock
   input  wire logic        rst,        // Asynchronous reset, active high
   input  wire logic        cap_req,    // Qualifying capture this cycle
   input  wire logic        lock_en,    // Capture lock enable
   input  wire logic        flag_set,   // Slot status flag still pending
   input  wire logic [63:0] ts_clock,   // Current time
   input  wire logic [15:0] seq_id,     // Sequence id of the message
   input  wire logic [15:0] src_id,     // Source identity tag
   output logic [63:0] clk_q,           // Captured time
   output logic [31:0] ids_q            // Captured {source id, sequence id}
);

   // ------------------------------------------------------------------
   // Capture storage
   // ------------------------------------------------------------------
   logic [63:0] clk_reg;   // Stored time
   logic [63:0] clk_next;
   logic [31:0] ids_reg;   // Stored identity
   logic [31:0] ids_next;

   // Overwrite unless locked and a previous capture is unread
   always_comb begin
      clk_next = clk_reg;
      ids_next = ids_reg;
      if (cap_req && !(lock_en && flag_set)) begin
         clk_next = ts_clock;
         ids_next = {src_id, seq_id};
      end
   end

   // Storage registers
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         clk_reg <= 64'h0000000000000000;
         ids_reg <= 32'h00000000;
      end else begin
         clk_reg <= clk_next;
         ids_reg <= ids_next;
      end
   end

   assign clk_q = clk_reg;
   assign ids_q = ids_reg;

endmodule : ppc_capture_slot

/* hw/ppc_pkg.sv */
// Purpose : Shared constants for the PTP port capture configuration block
// Assumes : APB slave with 32-bit data, one aligned word per register
// Notes   : Offsets are byte addresses; capture slots follow the fixed registers
package ppc_pkg;

   // ------------------------------------------------------------------
   // Register byte offsets
   // ------------------------------------------------------------------
   localparam logic [11:0] PPC_OFS_CFG      = 12'h000;  // Capture port configuration
   localparam logic [11:0] PPC_OFS_AUX_HI   = 12'h004;  // Auxiliary address bits 47:32
   localparam logic [11:0] PPC_OFS_AUX_LO   = 12'h008;  // Auxiliary address bits 31:0
   localparam logic [11:0] PPC_OFS_INT_STS  = 12'h00C;  // Sticky capture flags, W1C
   localparam logic [11:0] PPC_OFS_INT_MASK = 12'h010;  // Interrupt mask
   localparam logic [11:0] PPC_OFS_SLOT0    = 12'h020;  // First capture slot
   localparam logic [11:0] PPC_SLOT_STRIDE  = 12'h010;  // Bytes per capture slot
   localparam logic [3:0]  PPC_SUB_CLK_LO   = 4'h0;     // Slot word: clock low
   localparam logic [3:0]  PPC_SUB_CLK_HI   = 4'h4;     // Slot word: clock high
   localparam logic [3:0]  PPC_SUB_IDS      = 4'h8;     // Slot word: {source id, sequence}

   // ------------------------------------------------------------------
   // Configuration field positions
   // ------------------------------------------------------------------
   localparam int PPC_BIT_LOCK_RX_P1 = 17;  // Port 1 receive capture lock
   localparam int PPC_BIT_LOCK_TX_P1 = 16;  // Port 1 transmit capture lock
   localparam int PPC_BIT_ROLE_P0    = 15;  // time_master_role_p0
   localparam int PPC_BIT_PRI_P0     = 14;  // primary_ptp_addr_en_p0
   localparam int PPC_BIT_ALT_A_P0   = 13;  // alt_ptp_addr_a_en_p0
   localparam int PPC_BIT_ALT_B_P0   = 12;  // alt_ptp_addr_b_en_p0
   localparam int PPC_BIT_ALT_C_P0   = 11;  // alt_ptp_addr_c_en_p0
   localparam int PPC_BIT_AUX_P0     = 10;  // aux_ptp_addr_en_p0
   localparam int PPC_BIT_LOCK_RX_P0 = 9;   // Port 0 receive capture lock
   localparam int PPC_BIT_LOCK_TX_P0 = 8;   // Port 0 transmit capture lock
   localparam logic [31:0] PPC_CFG_WMASK = 32'h0003FF00;  // Writable bits 17:8

   // ------------------------------------------------------------------
   // Reset values
   // ------------------------------------------------------------------
   localparam logic [31:0] PPC_CFG_RESET  = 32'h00034300;  // Locks and primary set
   localparam logic [15:0] PPC_AUX_HI_RST = 16'h0000;
   localparam logic [31:0] PPC_AUX_LO_RST = 32'h00000000;
   localparam logic [3:0]  PPC_STS_RESET  = 4'h0;
   localparam logic [3:0]  PPC_MASK_RESET = 4'h0;

   // ------------------------------------------------------------------
   // Fixed PTP destination addresses (primary, then alternates a..c)
   // ------------------------------------------------------------------
   localparam logic [47:0] PPC_ADDR_PRI   = 48'h01005E000181;
   localparam logic [47:0] PPC_ADDR_ALT_A = 48'h01005E000182;
   localparam logic [47:0] PPC_ADDR_ALT_B = 48'h01005E000183;
   localparam logic [47:0] PPC_ADDR_ALT_C = 48'h01005E000184;

   // ------------------------------------------------------------------
   // Slot numbering, also the status and mask bit positions
   // ------------------------------------------------------------------
   localparam int PPC_NUM_SLOTS = 4;
   localparam int PPC_SLOT_P0_RX = 0;  // Port 0, data from the fabric
   localparam int PPC_SLOT_P0_TX = 1;  // Port 0, data to the fabric
   localparam int PPC_SLOT_P1_RX = 2;
   localparam int PPC_SLOT_P1_TX = 3;

   // PTP message types seen on the port 0 paths
   typedef enum logic [3:0] {
      PPC_MSG_SYNC      = 4'h0,
      PPC_MSG_DELAY_REQ = 4'h1
   } ppc_msg_type;

   // APB handshake states
   typedef enum logic [0:0] {
      PPC_BUS_IDLE = 1'b0,
      PPC_BUS_DONE = 1'b1
   } ppc_bus_type;

endpackage : ppc_pkg

/* testbench/ppc_capture_cfg_bench.sv */
// Purpose: Register and capture tests over APB
// Assumes: Slave answers in its own time; the bench waits for pready
// Notes  : Ids word equals the low clock word by model choice
module ppc_capture_cfg_bench import ppc_pkg::*; ;
   timeunit 1ns;
   timeprecision 1ns;
   logic        clk_sys, rst, psel, penable, pwrite, pready, pslverr, irq, err_q;
   logic [11:0] paddr, base;
   logic [31:0] pwdata, prdata, rd_q;
   logic [63:0] ts_clock, t;
   logic [3:0]  fv, msg;
   logic [47:0] dst;
   logic [15:0] seq, src;
   logic [47:0] adr [5] = '{PPC_ADDR_PRI, PPC_ADDR_ALT_A, PPC_ADDR_ALT_B,
                            PPC_ADDR_ALT_C, 48'h123456789ABC};
   int          lb [4] = '{9, 8, 17, 16};  // Lock bit per slot
   int          n_fail = 0;
   int          cmp_count = 0;
   ppc_capture_cfg dut_u (.clk_sys, .rst, .psel, .penable, .pwrite, .paddr, .pwdata,
      .prdata, .pready, .pslverr, .ts_clock, .p0_from_fab_valid(fv[0]),
      .p0_from_fab_msg(msg), .p0_from_fab_dst(dst), .p0_from_fab_seq(seq),
      .p0_from_fab_src(src), .p0_to_fab_valid(fv[1]), .p0_to_fab_msg(msg),
      .p0_to_fab_dst(dst), .p0_to_fab_seq(seq), .p0_to_fab_src(src),
      .p1_rx_event(fv[2]), .p1_rx_seq(seq), .p1_rx_src(src), .p1_tx_event(fv[3]),
      .p1_tx_seq(seq), .p1_tx_src(src), .irq);
   ppc_fabric_model fab_u (.clk_sys, .ts_clock, .valid(fv), .msg, .dst, .seq, .src);
   initial begin
      clk_sys = 1'b0;
      forever #50 clk_sys = ~clk_sys;
   end
   // One APB transfer; read data and error taken at the pready edge
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      int k;
      k = 0;
      @(posedge clk_sys);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk_sys);
      penable <= 1'b1;
      do begin
         @(posedge clk_sys);
         k++;
      end while (pready !== 1'b1 && k < 20);
      if (k >= 20) n_fail++;
      rd_q = prdata;
      err_q = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      cmp_count++;
      if (g !== e) begin
         n_fail++;
         $display("wrong value %s expected %h seen %h", nm, e, g);
      end
   endtask : chk
   task automatic summarize();
      $display("compares %0d mismatches %0d", cmp_count, n_fail);
      if (n_fail == 0 && cmp_count > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask : summarize
   // Read a slot back: clock low, clock high, ids
   task automatic slot(input logic [63:0] v);
      apb(0, base + 12'(PPC_SUB_CLK_LO), 0);
      chk("clk lo", v[31:0], rd_q);
      apb(0, base + 12'(PPC_SUB_CLK_HI), 0);
      chk("clk hi", v[63:32], rd_q);
      apb(0, base + 12'(PPC_SUB_IDS), 0);
      chk("ids", v[31:0], rd_q);
   endtask : slot
   task automatic ev(input int s, input logic [63:0] v);
      fab_u.send(s, s == 1 ? PPC_MSG_DELAY_REQ : PPC_MSG_SYNC, PPC_ADDR_PRI, v);
   endtask : ev
   task automatic irq_is(input logic e);
      repeat (2) @(posedge clk_sys);
      #1 chk("irq", {31'h0, e}, {31'h0, irq});
   endtask : irq_is
   initial begin
      repeat (5000) @(posedge clk_sys);
      n_fail++;
      summarize();
   end
   initial begin
      {rst, psel, penable, pwrite, paddr, pwdata} = {1'b1, 47'h0};
      repeat (10) @(posedge clk_sys);
      rst <= 1'b0;
      apb(0, PPC_OFS_CFG, 0);
      chk("cfg reset", PPC_CFG_RESET, rd_q);
      for (int i = 0; i < 4; i++) begin
         apb(0, PPC_OFS_AUX_HI + 12'(4 * i), 0);
         chk("zero reset", 32'h0, rd_q);
      end
      apb(0, 12'h014, 0);
      chk("unmapped err", 32'h1, {31'h0, err_q});
      apb(1, PPC_OFS_CFG, 32'hFFFFFFFF);
      apb(0, PPC_OFS_CFG, 0);
      chk("cfg mask", PPC_CFG_WMASK, rd_q);
      $display("test registers done");
      for (int r = 0; r < 2; r++)
         for (int p = 0; p < 2; p++)
            for (int m = 0; m < 2; m++) begin
               apb(1, PPC_OFS_CFG, PPC_CFG_RESET | (32'(r) << PPC_BIT_ROLE_P0));
               apb(1, PPC_OFS_INT_STS, 32'hF);
               fab_u.send(p, 4'(m), PPC_ADDR_PRI, 64'h0);
               apb(0, PPC_OFS_INT_STS, 0);
               chk("role", ((p == 0) == (m == r)) ? 32'h1 << p : 32'h0, rd_q);
            end
      $display("test role done");
      apb(1, PPC_OFS_AUX_HI, 32'h1234);
      apb(1, PPC_OFS_AUX_LO, 32'h56789ABC);
      for (int i = 0; i < 5; i++)
         for (int on = 0; on < 2; on++) begin
            apb(1, PPC_OFS_CFG, on ? 32'h1 << (14 - i) : 32'h7C00 ^ (32'h1 << (14 - i)));
            apb(1, PPC_OFS_INT_STS, 32'hF);
            fab_u.send(0, PPC_MSG_SYNC, adr[i], 64'h0);
            apb(0, PPC_OFS_INT_STS, 0);
            chk("addr", 32'(on), rd_q);
         end
      $display("test address done");
      for (int s = 0; s < 4; s++) begin
         base = PPC_OFS_SLOT0 + 12'(16 * s);
         t = 64'h0123456789ABCDEF + 64'(s);
         apb(1, PPC_OFS_CFG, PPC_CFG_RESET);
         apb(1, PPC_OFS_INT_STS, 32'hF);
         ev(s, t);
         ev(s, ~t);
         slot(t);
         irq_is(1'b0);
         apb(1, PPC_OFS_INT_MASK, 32'h1 << s);
         irq_is(1'b1);
         apb(1, PPC_OFS_INT_STS, 32'h1 << s);
         irq_is(1'b0);
         ev(s, ~t);
         slot(~t);
         apb(1, PPC_OFS_CFG, PPC_CFG_RESET & ~(32'h1 << lb[s]));
         ev(s, t);
         slot(t);
         apb(1, PPC_OFS_INT_MASK, 32'h0);
      end
      $display("test lock done");
      summarize();
   end
endmodule : ppc_capture_cfg_bench
bind ppc_capture_cfg ppc_cfg_props chk_u (.clk_sys, .rst, .psel, .penable, .pwrite,
   .prdata, .pready, .pslverr, .p0_from_fab_valid, .p0_to_fab_valid, .p1_rx_event,
   .p1_tx_event, .irq);

/* testbench/ppc_capture_cfg_properties.sv */
// Purpose: Port checks for the capture configuration block
// Assumes: One clk_sys domain, rst asynchronous and active high
// Notes  : Bound from the bench top file
module ppc_cfg_props (
   input wire logic        clk_sys,
   input wire logic        rst,
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pwrite,
   input wire logic [31:0] prdata,
   input wire logic        pready,
   input wire logic        pslverr,
   input wire logic        p0_from_fab_valid,
   input wire logic        p0_to_fab_valid,
   input wire logic        p1_rx_event,
   input wire logic        p1_tx_event,
   input wire logic        irq
);
   timeunit 1ns;
   timeprecision 1ns;
   logic any_ev;  // Any capture strobe this cycle
   assign any_ev = p0_from_fab_valid || p0_to_fab_valid || p1_rx_event || p1_tx_event;
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (rst);
   // Access phase waiting, then a one-cycle answer
   sequence s_wait; psel && penable && !pready; endsequence
   sequence s_ans; pready ##1 !pready; endsequence
   AST_RDY_ANS: assert property (s_wait |=> s_ans) else $error("pready not one cycle later");
   AST_NO_REQ: assert property (!psel |=> !pready) else $error("pready without request");
   AST_ACC_ONLY: assert property (pready |-> psel && penable) else $error("pready off access");
   AST_ERR_RDY: assert property (pslverr |-> pready) else $error("pslverr without pready");
   AST_PRD_IDLE: assert property (!pready |-> prdata == 32'h0) else $error("prdata not idle");
   AST_ERR_ZERO: assert property (pslverr |-> prdata == 32'h0) else $error("prdata on error");
   // irq is registered from the next flag and mask, so its cause stands one tick back
   AST_IRQ_SET: assert property ($rose(irq) |-> $past(any_ev, 1)
      || $past(pready && pwrite, 1)) else $error("irq rose without cause");
   AST_IRQ_CLR: assert property ($fell(irq) |-> $past(pready && pwrite, 1))
      else $error("irq fell without write");
endmodule : ppc_cfg_props

/* testbench/ppc_fabric_model.sv */
// Purpose: Packet path model driving capture strobes and time
// Assumes: Path 0 from fabric, 1 to fabric, 2 port 1 rx, 3 port 1 tx
// Notes  : Fields are inverted once a strobe is released
module ppc_fabric_model
   import ppc_pkg::*;
(
   input  wire logic   clk_sys,   // System clock
   output logic [63:0] ts_clock,  // Current time
   output logic [3:0]  valid,     // One strobe per path
   output logic [3:0]  msg,       // Message type
   output logic [47:0] dst,       // Destination address
   output logic [15:0] seq,       // Sequence id
   output logic [15:0] src        // Source identity
);
   timeunit 1ns;
   timeprecision 1ns;
   initial begin
      ts_clock = 64'h0;
      valid = 4'h0;
      msg = 4'h0;
      dst = 48'h0;
      seq = 16'h0;
      src = 16'h0;
   end
   // One-cycle strobe; time and ids come from t
   task automatic send(input int p, input logic [3:0] m, input logic [47:0] d,
                       input logic [63:0] t);
      @(posedge clk_sys);
      valid[p] <= 1'b1;  // Path 0 leaves the fabric, path 1 enters it
      msg <= m;
      dst <= d;
      {src, seq} <= t[31:0];
      ts_clock <= t;
      @(posedge clk_sys);
      valid <= 4'h0;
      msg <= ~m;
      dst <= ~d;
      {src, seq} <= ~t[31:0];
      ts_clock <= ~t;
   endtask : send
endmodule : ppc_fabric_model
